// File: hdl/kpx_regs.svh
// Register offsets, field layout, reset values and input counts of the input bias/irq block
`ifndef KPX_REGS_SVH
`define KPX_REGS_SVH

`define KPX_OFS_INT_STAT_A   8'h13
`define KPX_OFS_INT_STAT_B   8'h14
`define KPX_OFS_PULL_B       8'h18
`define KPX_OFS_PULL_C       8'h19
`define KPX_OFS_PULL_D       8'h1A
`define KPX_OFS_LEVEL_A      8'h1B
`define KPX_OFS_LEVEL_B      8'h1C
`define KPX_OFS_EVT_EN_A     8'h1D
`define KPX_OFS_EVT_EN_B     8'h1E
`define KPX_OFS_INT_EN_A     8'h1F
`define KPX_OFS_INT_EN_B     8'h20

`define KPX_MASK_PULL_B      8'h0F
`define KPX_MASK_PULL_B_NOR5 8'h03
`define KPX_MASK_PULL_D      8'h03
`define KPX_MASK_GRP_A       8'h3F
`define KPX_MASK_GRP_A_NO6   8'h1F
`define KPX_MASK_GRP_B       8'h1F

`define KPX_RST_ZERO         8'h00
`define KPX_RST_PULL_B_V2    8'h03
`define KPX_RST_PULL_B_V4    8'h05
`define KPX_RST_PULL_C_V4    8'h55
`define KPX_RST_PULL_D_V2    8'h03
`define KPX_RST_PULL_D_V4    8'h01

`define KPX_NUM_INPUTS       11
`define KPX_NUM_ROW_INPUTS   6
`define KPX_ROW6_INPUT       5

`endif

// File: hdl/kpx_pkg.sv
// Types shared by the input bias/irq block
package kpx_pkg;

    typedef enum logic [1:0]
    {
        KPX_BIAS_PU_WEAK   = 2'h0,
        KPX_BIAS_PD        = 2'h1,
        KPX_BIAS_PU_STRONG = 2'h2,
        KPX_BIAS_NONE      = 2'h3
    } kpx_bias_t;

    typedef logic [10:0] kpx_vec_t;

endpackage

// File: hdl/kpx_if.sv
// Per-input signals between the register core and the input lanes
`timescale 1ns/1ps
interface kpx_if;
    logic [10:0] pin;
    logic [10:0] polarity;
    logic [10:0] clr;
    logic [10:0] int_en;
    logic [10:0] evt_en;
    wire  [10:0] flag;
    wire  [10:0] irq;

    modport lane (input pin, input polarity, input clr, input int_en, input evt_en,
                  output flag, output irq);
    modport core (output pin, output polarity, output clr, output int_en, output evt_en,
                  input flag, input irq);
endinterface

// File: hdl/kpx_lane.sv
// One input lane: level-sensitive sticky flag with clear-on-read and irq gating
`timescale 1ns/1ps
module kpx_lane #(
    parameter int IDX  = 0,
    parameter bit LIVE = 1'b1
) (
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic resetn_i,
    // Lane signals
    kpx_if.lane       lif
);

    logic flag;
    logic next_flag;
    logic active;

    always_comb
    begin
        // Polarity 0 matches a low pin, 1 a high pin; a dead lane never sets
        active    = LIVE && (lif.pin[IDX] == lif.polarity[IDX]);
        // Level keeps winning over the read clear, so no sample is lost
        next_flag = active | (flag & ~lif.clr[IDX]);
    end

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            flag <= 1'b0;
        else
            flag <= next_flag;
    end

    assign lif.flag[IDX] = flag;
    assign lif.irq[IDX]  = flag & lif.int_en[IDX] & ~lif.evt_en[IDX];

endmodule

// File: hdl/kpx_top.sv
// Input bias selection and interrupt-level control register block
`timescale 1ns/1ps
`include "kpx_regs.svh"
module kpx_top #(
    // Factory variant 0..4; variant 1 exposes the sixth row input
    parameter int VARIANT = 0
) (
    // Clock and reset
    input  wire logic        CORE_CLK_I,
    input  wire logic        RESETN_I,
    // Register access from the serial port engine
    input  wire logic [7:0]  REG_ADDR_I,
    input  wire logic        REG_WR_I,
    input  wire logic        REG_RD_I,
    input  wire logic [7:0]  REG_WDATA_I,
    output logic      [7:0]  REG_RDATA_O,
    output logic             REG_RVALID_O,
    // Input pins
    input  wire logic [5:0]  ROW_PIN_I,
    input  wire logic [4:0]  COL_PIN_I,
    // Bias controls for row 4, row 5, column 0..4 (index 0..6)
    output logic      [13:0] BIAS_CODE_O,
    output logic      [6:0]  PULLUP_WEAK_EN_O,
    output logic      [6:0]  PULLDOWN_EN_O,
    output logic      [6:0]  PULLUP_STRONG_EN_O,
    // Aggregate input interrupt
    output logic             AGG_INPUT_IRQ_O
);

    localparam bit ROW6_LIVE = (VARIANT == 1);

    localparam logic [7:0] RST_PULL_B = (VARIANT == 2) ? `KPX_RST_PULL_B_V2 :
                                        (VARIANT == 4) ? `KPX_RST_PULL_B_V4 :
                                        `KPX_RST_ZERO;
    localparam logic [7:0] RST_PULL_C = (VARIANT == 4) ? `KPX_RST_PULL_C_V4 :
                                        `KPX_RST_ZERO;
    localparam logic [7:0] RST_PULL_D = (VARIANT == 2) ? `KPX_RST_PULL_D_V2 :
                                        (VARIANT == 4) ? `KPX_RST_PULL_D_V4 :
                                        `KPX_RST_ZERO;

    // Writable masks; the row 5 and input 6 bits only exist in the six-row variant
    localparam logic [7:0] WMASK_PULL_B = ROW6_LIVE ? `KPX_MASK_PULL_B :
                                          `KPX_MASK_PULL_B_NOR5;
    localparam logic [7:0] WMASK_GRP_A  = ROW6_LIVE ? `KPX_MASK_GRP_A :
                                          `KPX_MASK_GRP_A_NO6;

    // Configuration storage
    logic [7:0]        pull_b;
    logic [7:0]        pull_c;
    logic [7:0]        pull_d;
    logic [7:0]        level_a;
    logic [7:0]        level_b;
    logic [7:0]        evt_en_a;
    logic [7:0]        evt_en_b;
    logic [7:0]        int_en_a;
    logic [7:0]        int_en_b;
    logic [7:0]        next_pull_b;
    logic [7:0]        next_pull_c;
    logic [7:0]        next_pull_d;
    logic [7:0]        next_level_a;
    logic [7:0]        next_level_b;
    logic [7:0]        next_evt_en_a;
    logic [7:0]        next_evt_en_b;
    logic [7:0]        next_int_en_a;
    logic [7:0]        next_int_en_b;

    // Read port and pin outputs
    logic [7:0]        rdata;
    logic              rvalid;
    logic [13:0]       bias;
    logic [6:0]        pu_weak;
    logic [6:0]        pd;
    logic [6:0]        pu_strong;
    logic              agg_irq;
    logic [7:0]        next_rdata;
    logic              next_rvalid;
    logic [13:0]       next_bias;
    logic [6:0]        next_pu_weak;
    logic [6:0]        next_pd;
    logic [6:0]        next_pu_strong;
    logic              next_agg_irq;

    kpx_if lanes ();

    genvar g;
    generate
        for (g = 0; g < `KPX_NUM_INPUTS; g++)
        begin : g_lane
            kpx_lane #(
                .IDX  (g),
                .LIVE ((g != `KPX_ROW6_INPUT) || ROW6_LIVE)
            ) u_lane (
                .clk_i    (CORE_CLK_I),
                .resetn_i (RESETN_I),
                .lif      (lanes)
            );
        end
    endgenerate

    // Inputs 1..6 are rows 0..5, inputs 7..11 are columns 0..4
    assign lanes.pin      = {COL_PIN_I, ROW_PIN_I};
    assign lanes.polarity = {level_b[4:0], level_a[5:0]};
    assign lanes.int_en   = {int_en_b[4:0], int_en_a[5:0]};
    assign lanes.evt_en   = {evt_en_b[4:0], evt_en_a[5:0]};

    // Status reads clear the group they return
    always_comb
    begin
        lanes.clr = 11'h000;
        if (REG_RD_I && (REG_ADDR_I == `KPX_OFS_INT_STAT_A))
            lanes.clr[5:0] = 6'h3F;
        if (REG_RD_I && (REG_ADDR_I == `KPX_OFS_INT_STAT_B))
            lanes.clr[10:6] = 5'h1F;
    end

    // Writes to pull_b leave its reserved bits alone, so a factory preset there survives; the other registers store zeros there
    always_comb
    begin
        next_pull_b   = pull_b;
        next_pull_c   = pull_c;
        next_pull_d   = pull_d;
        next_level_a  = level_a;
        next_level_b  = level_b;
        next_evt_en_a = evt_en_a;
        next_evt_en_b = evt_en_b;
        next_int_en_a = int_en_a;
        next_int_en_b = int_en_b;
        if (REG_WR_I)
        begin
            unique case (REG_ADDR_I)
                `KPX_OFS_PULL_B:   next_pull_b   = (REG_WDATA_I & WMASK_PULL_B) |
                                                   (pull_b & ~WMASK_PULL_B);
                `KPX_OFS_PULL_C:   next_pull_c   = REG_WDATA_I;
                `KPX_OFS_PULL_D:   next_pull_d   = REG_WDATA_I & `KPX_MASK_PULL_D;
                `KPX_OFS_LEVEL_A:  next_level_a  = REG_WDATA_I & WMASK_GRP_A;
                `KPX_OFS_LEVEL_B:  next_level_b  = REG_WDATA_I & `KPX_MASK_GRP_B;
                `KPX_OFS_EVT_EN_A: next_evt_en_a = REG_WDATA_I & WMASK_GRP_A;
                `KPX_OFS_EVT_EN_B: next_evt_en_b = REG_WDATA_I & `KPX_MASK_GRP_B;
                `KPX_OFS_INT_EN_A: next_int_en_a = REG_WDATA_I & WMASK_GRP_A;
                `KPX_OFS_INT_EN_B: next_int_en_b = REG_WDATA_I & `KPX_MASK_GRP_B;
                default:           next_pull_b   = pull_b;
            endcase
        end
    end

    always_ff @(posedge CORE_CLK_I or negedge RESETN_I)
    begin
        if (!RESETN_I)
        begin
            pull_b   <= RST_PULL_B;
            pull_c   <= RST_PULL_C;
            pull_d   <= RST_PULL_D;
            level_a  <= `KPX_RST_ZERO;
            level_b  <= `KPX_RST_ZERO;
            evt_en_a <= `KPX_RST_ZERO;
            evt_en_b <= `KPX_RST_ZERO;
            int_en_a <= `KPX_RST_ZERO;
            int_en_b <= `KPX_RST_ZERO;
        end
        else
        begin
            pull_b   <= next_pull_b;
            pull_c   <= next_pull_c;
            pull_d   <= next_pull_d;
            level_a  <= next_level_a;
            level_b  <= next_level_b;
            evt_en_a <= next_evt_en_a;
            evt_en_b <= next_evt_en_b;
            int_en_a <= next_int_en_a;
            int_en_b <= next_int_en_b;
        end
    end

    // Read data, bias decode and aggregate irq, all registered
    always_comb
    begin
        next_rvalid = REG_RD_I;
        next_rdata  = 8'h00;
        if (REG_RD_I)
        begin
            unique case (REG_ADDR_I)
                `KPX_OFS_INT_STAT_A: next_rdata = {2'h0, lanes.flag[5:0]};
                `KPX_OFS_INT_STAT_B: next_rdata = {3'h0, lanes.flag[10:6]};
                `KPX_OFS_PULL_B:     next_rdata = pull_b;
                `KPX_OFS_PULL_C:     next_rdata = pull_c;
                `KPX_OFS_PULL_D:     next_rdata = pull_d;
                `KPX_OFS_LEVEL_A:    next_rdata = level_a;
                `KPX_OFS_LEVEL_B:    next_rdata = level_b;
                `KPX_OFS_EVT_EN_A:   next_rdata = evt_en_a;
                `KPX_OFS_EVT_EN_B:   next_rdata = evt_en_b;
                `KPX_OFS_INT_EN_A:   next_rdata = int_en_a;
                `KPX_OFS_INT_EN_B:   next_rdata = int_en_b;
                default:             next_rdata = 8'h00;
            endcase
        end
        // Pin order: row 4, row 5, column 0..4
        next_bias = {pull_d[1:0], pull_c, pull_b[3:0]};
        for (int i = 0; i < 7; i++)
        begin
            next_pu_weak[i]   = (next_bias[2*i +: 2] == kpx_pkg::KPX_BIAS_PU_WEAK);
            next_pd[i]        = (next_bias[2*i +: 2] == kpx_pkg::KPX_BIAS_PD);
            next_pu_strong[i] = (next_bias[2*i +: 2] == kpx_pkg::KPX_BIAS_PU_STRONG);
        end
        // The dead row 5 pin is left unbiased rather than obeying a preset
        if (!ROW6_LIVE)
        begin
            next_pu_weak[1]   = 1'b0;
            next_pd[1]        = 1'b0;
            next_pu_strong[1] = 1'b0;
        end
        next_agg_irq = |lanes.irq;
    end

    always_ff @(posedge CORE_CLK_I or negedge RESETN_I)
    begin
        if (!RESETN_I)
        begin
            rdata     <= 8'h00;
            rvalid    <= 1'b0;
            bias      <= 14'h0000;
            pu_weak   <= 7'h00;
            pd        <= 7'h00;
            pu_strong <= 7'h00;
            agg_irq   <= 1'b0;
        end
        else
        begin
            rdata     <= next_rdata;
            rvalid    <= next_rvalid;
            bias      <= next_bias;
            pu_weak   <= next_pu_weak;
            pd        <= next_pd;
            pu_strong <= next_pu_strong;
            agg_irq   <= next_agg_irq;
        end
    end

    assign REG_RDATA_O        = rdata;
    assign REG_RVALID_O       = rvalid;
    assign BIAS_CODE_O        = bias;
    assign PULLUP_WEAK_EN_O   = pu_weak;
    assign PULLDOWN_EN_O      = pd;
    assign PULLUP_STRONG_EN_O = pu_strong;
    assign AGG_INPUT_IRQ_O    = agg_irq;

endmodule

// File: dv/kpx_top_props.sv
// Concurrent checks on the ports of the bias and irq-level block
`timescale 1ns/1ps
module kpx_top_props #(
    parameter int VARIANT = 0
) (
    // Clock and reset
    input  wire logic        CORE_CLK_I,
    input  wire logic        RESETN_I,
    // Register port
    input  wire logic [7:0]  REG_ADDR_I,
    input  wire logic        REG_WR_I,
    input  wire logic        REG_RD_I,
    input  wire logic [7:0]  REG_WDATA_I,
    input  wire logic [7:0]  REG_RDATA_O,
    input  wire logic        REG_RVALID_O,
    // Bias outputs
    input  wire logic [13:0] BIAS_CODE_O,
    input  wire logic [6:0]  PULLUP_WEAK_EN_O,
    input  wire logic [6:0]  PULLDOWN_EN_O,
    input  wire logic [6:0]  PULLUP_STRONG_EN_O
);
    logic [6:0] exp_w, exp_d, exp_s;
    // Row 5 decodes are dead outside the six-row variant
    always_comb
    begin
        for (int k = 0; k < 7; k++)
        begin
            exp_w[k] = (BIAS_CODE_O[2*k+:2] == 2'h0) && (k != 1 || VARIANT == 1);
            exp_d[k] = (BIAS_CODE_O[2*k+:2] == 2'h1) && (k != 1 || VARIANT == 1);
            exp_s[k] = (BIAS_CODE_O[2*k+:2] == 2'h2) && (k != 1 || VARIANT == 1);
        end
    end
    default clocking cb @(posedge CORE_CLK_I); endclocking
    default disable iff (!RESETN_I);
    a_dec_weak_up: assert property ($past(RESETN_I) |-> PULLUP_WEAK_EN_O == exp_w)
        else $error("weak pull-up decode wrong");
    a_dec_pull_down: assert property ($past(RESETN_I) |-> PULLDOWN_EN_O == exp_d)
        else $error("pull-down decode wrong");
    a_dec_strong_up: assert property ($past(RESETN_I) |-> PULLUP_STRONG_EN_O == exp_s)
        else $error("strong pull-up decode wrong");
    // Bias outputs trail a write by two edges: register, then output flop
    a_wr_row_high: assert property (REG_WR_I && REG_ADDR_I == 8'h18 |-> ##2
        (BIAS_CODE_O[1:0] == $past(REG_WDATA_I[1:0], 2) &&
        (VARIANT == 1 || $stable(BIAS_CODE_O[3:2]))))
        else $error("row bias write wrong");
    a_wr_col_low: assert property (REG_WR_I && REG_ADDR_I == 8'h19 |-> ##2
        BIAS_CODE_O[11:4] == $past(REG_WDATA_I, 2)) else $error("column bias write wrong");
    a_wr_col_high: assert property (REG_WR_I && REG_ADDR_I == 8'h1A |-> ##2
        BIAS_CODE_O[13:12] == $past(REG_WDATA_I[1:0], 2))
        else $error("column 4 bias write wrong");
    a_rd_reserved_zero: assert property (REG_RD_I && REG_ADDR_I == 8'h1A |=>
        REG_RVALID_O && REG_RDATA_O[7:2] == 6'h00) else $error("reserved bits read nonzero");
    a_rd_level_b: assert property (REG_RD_I && REG_ADDR_I == 8'h1C |=>
        REG_RVALID_O && REG_RDATA_O[7:5] == 3'h0) else $error("level register read wrong");
    c_status_read: cover property (REG_RD_I && REG_ADDR_I == 8'h13);
    c_col_write: cover property (REG_WR_I && REG_ADDR_I == 8'h19);
    c_no_pull: cover property (BIAS_CODE_O[13:12] == 2'h3);
endmodule

// File: dv/kpx_pins_model.sv
// Keypad line model: driven levels, or the bias level when released
`timescale 1ns/1ps
module kpx_pins_model (
    // Clock
    input  wire logic        clk_i,
    // Line control from the bench
    input  wire logic [10:0] drv_en_i,
    input  wire logic [10:0] drv_val_i,
    // Bias enables, index 0 is row 4
    input  wire logic [6:0]  pu_i,
    input  wire logic [6:0]  pd_i,
    // Lines into the device
    output logic      [5:0]  row_o,
    output logic      [4:0]  col_o
);
    logic        tgl = 1'b0;
    logic [10:0] rel;
    always @(negedge clk_i)
        tgl <= ~tgl;
    // A floating line wanders, so it never reads as a steady level
    assign rel = {pu_i, 4'h0} | (~{pu_i | pd_i, 4'h0} & {tgl, {5{~tgl, tgl}}});
    assign {col_o, row_o} = (drv_en_i & drv_val_i) | (~drv_en_i & rel);
endmodule

// File: dv/kpx_top_tb.sv
// Self-checking bench of the bias and irq-level block
`timescale 1ns/1ps
`define KCHK(g, e) begin comparisons++; if ((g) !== (e)) begin fails++; $display("unexpected at %0t: got %h exp %h", $time, g, e); end end
module kpx_top_tb;
    localparam int VARIANT = 4;
    logic        clk = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0;
    logic [7:0]  addr = 8'h00, wdata = 8'h00, rdata;
    logic [10:0] pin_val = 11'h7FF;
    logic [10:0] drv_en  = 11'h7FF;
    logic [13:0] bias;
    logic [6:0]  pw, pd, ps;
    logic        rvalid, agg;
    logic [5:0]  row;
    logic [4:0]  col;
    int          fails = 0, comparisons = 0, cyc = 0;
    always #25 clk = ~clk;
    kpx_pins_model kpx_pins_model_inst (.clk_i(clk), .drv_en_i(drv_en), .drv_val_i(pin_val),
        .pu_i(pw | ps), .pd_i(pd), .row_o(row), .col_o(col));
    kpx_top #(.VARIANT(VARIANT)) kpx_top_inst (.CORE_CLK_I(clk), .RESETN_I(rstn),
        .REG_ADDR_I(addr), .REG_WR_I(wr), .REG_RD_I(rd), .REG_WDATA_I(wdata),
        .REG_RDATA_O(rdata), .REG_RVALID_O(rvalid), .ROW_PIN_I(row), .COL_PIN_I(col),
        .BIAS_CODE_O(bias), .PULLUP_WEAK_EN_O(pw), .PULLDOWN_EN_O(pd),
        .PULLUP_STRONG_EN_O(ps), .AGG_INPUT_IRQ_O(agg));
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(negedge clk);
        wr = 1'b0;
    endtask
    // Read data stands one cycle only, so it is taken at the next falling edge
    task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
        @(negedge clk);
        addr = a;
        rd = 1'b1;
        @(negedge clk);
        rd = 1'b0;
        `KCHK({rvalid, rdata}, {1'b1, e})
    endtask
    task automatic report_and_stop;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            fails++;
            report_and_stop();
        end
    end
    task automatic t_reset;
        rd_reg(8'h18, 8'h05);
        rd_reg(8'h19, 8'h55);
        rd_reg(8'h1A, 8'h01);
        `KCHK({pw, pd, ps}, {7'h00, 7'h7D, 7'h00})
    endtask
    task automatic t_bias;
        logic [1:0] c;
        for (int i = 0; i < 4; i++)
        begin
            c = 2'(i);
            wr_reg(8'h19, {4{c}});
            wr_reg(8'h1A, {6'h3F, c});
            wr_reg(8'h18, {6'h3F, c});
            rd_reg(8'h1A, {6'h00, c});
            rd_reg(8'h18, {6'h01, c});
            `KCHK(bias[11:4], {4{c}})
            `KCHK({pw, pd, ps}, {{7{c == 2'h0}}, {7{c == 2'h1}}, {7{c == 2'h2}}} & 21'h1F7EFD)
        end
        wr_reg(8'h19, 8'hE4);
        @(negedge clk);
        `KCHK({pw[5:2], pd[5:2], ps[5:2]}, 12'h124)
    endtask
    task automatic t_irq;
        wr_reg(8'h1F, 8'h3F);
        wr_reg(8'h20, 8'h1F);
        `KCHK(agg, 1'b0)
        pin_val = 11'h7DE;
        repeat (2) @(negedge clk);
        `KCHK(agg, 1'b1)
        pin_val = 11'h7FF;
        rd_reg(8'h13, 8'h01);
        rd_reg(8'h13, 8'h00);
        @(negedge clk);
        `KCHK(agg, 1'b0)
        wr_reg(8'h1C, 8'h10);
        rd_reg(8'h14, 8'h10);
        wr_reg(8'h1E, 8'h10);
        repeat (3) @(negedge clk);
        `KCHK(agg, 1'b0)
        wr_reg(8'h1C, 8'h00);
        rd_reg(8'h14, 8'h10);
        rd_reg(8'h14, 8'h00);
        wr_reg(8'h1E, 8'h00);
    endtask
    task automatic t_level;
        wr_reg(8'h1B, 8'hFF);
        rd_reg(8'h1B, 8'h1F);
        wr_reg(8'h1C, 8'hFF);
        rd_reg(8'h1C, 8'h1F);
        rd_reg(8'h13, 8'h1F);
        rd_reg(8'h30, 8'h00);
    endtask
    // Released lines settle to their bias: column 0 pulled up, column 1 pulled down
    task automatic t_release;
        wr_reg(8'h1C, 8'h00);
        rd_reg(8'h14, 8'h1F);
        drv_en = 11'h73F;
        repeat (2) @(negedge clk);
        rd_reg(8'h14, 8'h02);
        drv_en = 11'h7FF;
        rd_reg(8'h14, 8'h02);
        rd_reg(8'h14, 8'h00);
    endtask
    initial
    begin
        repeat (20) @(negedge clk);
        rstn = 1'b1;
        t_reset();
        t_bias();
        t_irq();
        t_level();
        t_release();
        report_and_stop();
    end
endmodule
bind kpx_top kpx_top_props #(.VARIANT(VARIANT)) kpx_top_props_inst (
    .CORE_CLK_I(CORE_CLK_I), .RESETN_I(RESETN_I), .REG_ADDR_I(REG_ADDR_I),
    .REG_WR_I(REG_WR_I), .REG_RD_I(REG_RD_I), .REG_WDATA_I(REG_WDATA_I),
    .REG_RDATA_O(REG_RDATA_O), .REG_RVALID_O(REG_RVALID_O), .BIAS_CODE_O(BIAS_CODE_O),
    .PULLUP_WEAK_EN_O(PULLUP_WEAK_EN_O), .PULLDOWN_EN_O(PULLDOWN_EN_O),
    .PULLUP_STRONG_EN_O(PULLUP_STRONG_EN_O));
